// file: hdl/hub_port_pkg.sv
/*
  package for the hub downstream port connect/enable block: register offsets,
  reset values, timing figures and the line state type.
  assumes a 250 MHz system clock.
*/
package hub_port_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ATTACH_STATUS_OFS = 8'h48;
  localparam logic [7:0] PORT_ENABLE_OFS   = 8'h49;
  localparam logic [7:0] SPEED_SELECT_OFS  = 8'h4A;
  localparam logic [7:0] HUB_CTRL_OFS      = 8'h4C;
  localparam logic [7:0] REG_RESET_VAL     = 8'h00;

  // hub control register fields
  localparam int HUB_CTRL_SUSPEND_BIT = 0;
  localparam int HUB_CTRL_IRQ_EN_BIT  = 1;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int CONNECT_TIME_PS  = 2500000;
  localparam int DISCON_TIME_PS   = 2000000;
  // connect must exceed 2.5 us: one cycle past the rounded-up count
  localparam int CONNECT_CYCLES   = (CONNECT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  // disconnect at 2.0 us rounded up, inside the 2.0 to 2.5 us window
  localparam int DISCON_CYCLES    = (DISCON_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QUAL_CNT_W       = 10;

  // ----------------------------------------------------------------------
  // line states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LINE_SE0 = 2'b00,
    LINE_J   = 2'b01,
    LINE_K   = 2'b11,
    LINE_SE1 = 2'b10
  } line_state_t;

endpackage

// file: hdl/hub_port_connect_enable.sv
/*
  hub repeater logic for the downstream ports: attach qualification, status,
  speed and enable registers, deferred enable and repeat gating.
  assumes all inputs synchronous to ref_clk_i; upstream bus activity, packet
  end, babble, frame checkpoint and forcing are flagged by the serial engine.
*/
// Decided for this implementation: the strobed register port.
// Notes on behaviour
// - D+ low, D- high sets the port's attach flag and raises hub interrupt.
// - D+ high, D- low sets the port's attach flag and raises hub interrupt.
// - attach recorded only after non-SE0 lasts longer than 2.5 us.
// - SE0 for 2.0 to 2.5 us declares detach, clears flag, raises interrupt.
// - both lines low means nothing is attached on that port.
// - attach status holds one flag per port in bits 0 to 3.
// - attach status clears on chip or bus reset, then tracks real ports.
// - attach status bits 4 to 7 always read zero.
// - speed register bit per port, 1 low speed; bits 4 to 7 read zero.
// - speed register clears on resets; firmware programs it at port reset.
// - set enable bit opens the port for traffic both ways.
// - enabled awake port gets upstream traffic; sends upstream unless babbling.
// - full-speed upstream traffic never goes onto a low-speed port.
// - enabling write takes effect at packet end, or at once when idle.
// - in suspend, attach changes interrupt if enabled, even on disabled ports.
// - hub drives an end-of-packet at the first end-of-frame checkpoint.
// - serial engine does stuffing, CRC, handshakes, tokens, address match.
// - babble on a port clears that port's enable bit.
// - no attach interrupt while the port is being forced.
// - port enable register clears on chip or bus reset.
`timescale 1ns/1ns
module hub_port_connect_enable #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 bus_reset_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [7:0]           reg_rdata_o,
  input  wire logic [NUM_PORTS-1:0] dn_dp_i,
  input  wire logic [NUM_PORTS-1:0] dn_dm_i,
  input  wire logic [NUM_PORTS-1:0] port_forced_i,
  input  wire logic [NUM_PORTS-1:0] babble_i,
  input  wire logic                 up_busy_i,
  input  wire logic                 up_eop_i,
  input  wire logic                 up_full_speed_i,
  input  wire logic                 eof1_i,
  input  wire logic                 engine_suspend_i,
  output logic      [NUM_PORTS-1:0] dn_repeat_en_o,
  output logic      [NUM_PORTS-1:0] up_repeat_en_o,
  output logic                      eop_drive_o,
  output logic                      hub_irq_o
);
  import hub_port_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [NUM_PORTS-1:0] attach_reg;
  logic [NUM_PORTS-1:0] speed_reg;
  logic [NUM_PORTS-1:0] enable_reg;
  logic [NUM_PORTS-1:0] enable_pend_reg;
  logic [1:0]           hub_ctrl_reg;
  logic [7:0]           rdata_reg;
  logic                 irq_reg;
  logic                 eop_reg;
  logic [NUM_PORTS-1:0] change_w;

  wire logic clr_w      = bus_reset_i;
  wire logic wr_attach  = reg_wr_i && (reg_addr_i == ATTACH_STATUS_OFS);
  wire logic wr_enable  = reg_wr_i && (reg_addr_i == PORT_ENABLE_OFS);
  wire logic wr_speed   = reg_wr_i && (reg_addr_i == SPEED_SELECT_OFS);
  wire logic wr_ctrl    = reg_wr_i && (reg_addr_i == HUB_CTRL_OFS);
  wire logic bus_idle_w = !up_busy_i || up_eop_i;
  wire logic suspend_w  = hub_ctrl_reg[HUB_CTRL_SUSPEND_BIT];
  wire logic irq_en_w   = hub_ctrl_reg[HUB_CTRL_IRQ_EN_BIT];

  // ----------------------------------------------------------------------
  // per-port attach qualification
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [1:0]            line_reg;
    logic [QUAL_CNT_W-1:0] cnt_reg;
    wire logic [1:0] line_w  = {dn_dm_i[p], dn_dp_i[p]};
    wire logic       se0_w   = (line_w == LINE_SE0);
    wire logic       same_w  = (line_w == line_reg);
    wire logic       con_ok  = !se0_w && same_w
                               && (cnt_reg == QUAL_CNT_W'(CONNECT_CYCLES - 1));
    wire logic       dis_ok  = se0_w && same_w
                               && (cnt_reg == QUAL_CNT_W'(DISCON_CYCLES - 1));
    wire logic       set_w   = con_ok && !attach_reg[p];
    wire logic       clr_a_w = dis_ok && attach_reg[p];
    assign change_w[p] = (set_w || clr_a_w) && !port_forced_i[p];

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        line_reg <= 2'b00;
        cnt_reg  <= '0;
      end else if (clk_en_i) begin
        line_reg <= line_w;
        if (!same_w || clr_w) begin
          cnt_reg <= '0;
        end else if (cnt_reg != QUAL_CNT_W'(CONNECT_CYCLES)) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        attach_reg[p] <= 1'b0;
      end else if (clk_en_i) begin
        if (clr_w) begin
          attach_reg[p] <= 1'b0;
        end else if (set_w) begin
          attach_reg[p] <= 1'b1;
        end else if (clr_a_w) begin
          attach_reg[p] <= 1'b0;
        end else if (wr_attach) begin
          attach_reg[p] <= reg_wdata_i[p];
        end
      end
    end

    // enable with deferral, babble disable
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        enable_reg[p]      <= 1'b0;
        enable_pend_reg[p] <= 1'b0;
      end else if (clk_en_i) begin
        if (clr_w) begin
          enable_reg[p]      <= 1'b0;
          enable_pend_reg[p] <= 1'b0;
        end else if (babble_i[p] && enable_reg[p]) begin
          enable_reg[p]      <= 1'b0;
          enable_pend_reg[p] <= 1'b0;
        end else if (wr_enable && !reg_wdata_i[p]) begin
          enable_reg[p]      <= 1'b0;
          enable_pend_reg[p] <= 1'b0;
        end else if ((wr_enable && reg_wdata_i[p]) || enable_pend_reg[p]) begin
          if (bus_idle_w) begin
            enable_reg[p]      <= 1'b1;
            enable_pend_reg[p] <= 1'b0;
          end else begin
            enable_pend_reg[p] <= 1'b1;
          end
        end
      end
    end

    // repeat gating
    assign dn_repeat_en_o[p] = enable_reg[p] && !engine_suspend_i
                               && !(speed_reg[p] && up_full_speed_i);
    assign up_repeat_en_o[p] = enable_reg[p] && !engine_suspend_i
                               && !babble_i[p];
  end

  // ----------------------------------------------------------------------
  // speed, control, interrupt, end-of-frame
  // ----------------------------------------------------------------------
  wire logic irq_next = |change_w && (!suspend_w || irq_en_w);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_reg    <= '0;
      hub_ctrl_reg <= 2'b00;
      irq_reg      <= 1'b0;
      eop_reg      <= 1'b0;
    end else if (clk_en_i) begin
      if (clr_w) begin
        speed_reg <= '0;
      end else if (wr_speed) begin
        speed_reg <= reg_wdata_i[NUM_PORTS-1:0];
      end
      if (wr_ctrl) begin
        hub_ctrl_reg <= reg_wdata_i[1:0];
      end
      irq_reg <= irq_next;
      eop_reg <= eof1_i;
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  wire logic [7:0] attach_w = 8'(attach_reg);
  wire logic [7:0] speed_w  = 8'(speed_reg);
  wire logic [7:0] enable_w = 8'(enable_reg);
  wire logic [7:0] ctrl_w   = 8'(hub_ctrl_reg);
  wire logic [7:0] rsel_w   = (reg_addr_i == ATTACH_STATUS_OFS) ? attach_w :
                              (reg_addr_i == PORT_ENABLE_OFS)   ? enable_w :
                              (reg_addr_i == SPEED_SELECT_OFS)  ? speed_w  :
                              (reg_addr_i == HUB_CTRL_OFS)      ? ctrl_w   : REG_RESET_VAL;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= REG_RESET_VAL;
    end else if (clk_en_i) begin
      rdata_reg <= reg_rd_i ? rsel_w : REG_RESET_VAL;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign hub_irq_o   = irq_reg;
  assign eop_drive_o = eop_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_change;
    clk_en_i && |change_w;
  endsequence

  AST_IRQ_PULSE: assert property ((s_change and !suspend_w) |=> hub_irq_o)
    else $error("attach change without interrupt");
  AST_IRQ_ONE: assert property (clk_en_i && !(|change_w) |=> !hub_irq_o)
    else $error("interrupt without change");
  AST_HIGH_ZERO: assert property (attach_w[7:4] == 4'h0 && speed_w[7:4] == 4'h0)
    else $error("reserved bits not zero");
  AST_BUS_RST: assert property (clk_en_i && bus_reset_i
                                |=> attach_reg == '0 && enable_reg == '0 && speed_reg == '0)
    else $error("bus reset did not clear registers");
  AST_NO_SE0_ATTACH: assert property (clk_en_i && $rose(attach_reg[0])
                                      |-> $past(dn_dp_i[0] | dn_dm_i[0]))
    else $error("attach set on SE0");
  AST_LS_BLOCK: assert property (speed_reg[0] && up_full_speed_i |-> !dn_repeat_en_o[0])
    else $error("full speed traffic to low speed port");
  AST_DEFER: assert property (clk_en_i && up_busy_i && !up_eop_i && !bus_reset_i
                              && !enable_reg[0] && !babble_i[0]
                              |=> !enable_reg[0])
    else $error("enable took effect mid packet");
  AST_BABBLE: assert property (clk_en_i && babble_i[0] && enable_reg[0]
                               |=> !enable_reg[0])
    else $error("babble did not disable port");
  AST_FORCED: assert property (port_forced_i == '1 |=> !hub_irq_o)
    else $error("interrupt from forced port");
  AST_EOP: assert property (clk_en_i && eof1_i |=> eop_drive_o)
    else $error("no end of packet at checkpoint");

  // ----------------------------------------------------------------------
  // interrupt, read port and gating checks
  // ----------------------------------------------------------------------
  sequence s_susp_change;
    clk_en_i && |change_w && suspend_w;
  endsequence

  sequence s_rd_hit;
    clk_en_i && reg_rd_i;
  endsequence

  AST_IRQ_SUSP_EN: assert property (
    (s_susp_change and irq_en_w)
    |=> hub_irq_o)
    else $error("suspended change without enabled interrupt");

  AST_IRQ_SUSP_MASK: assert property (
    (s_susp_change and !irq_en_w)
    |=> !hub_irq_o)
    else $error("suspended change raised masked interrupt");

  AST_RDATA_IDLE: assert property (
    clk_en_i && !reg_rd_i
    |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");

  AST_RD_ATTACH: assert property (
    (s_rd_hit and reg_addr_i == ATTACH_STATUS_OFS)
    |=> reg_rdata_o == $past(attach_w))
    else $error("attach status read wrong");

  AST_RD_SPEED: assert property (
    (s_rd_hit and reg_addr_i == SPEED_SELECT_OFS)
    |=> reg_rdata_o == $past(speed_w))
    else $error("speed read wrong");

  AST_RD_ENABLE: assert property (
    (s_rd_hit and reg_addr_i == PORT_ENABLE_OFS)
    |=> reg_rdata_o == $past(enable_w))
    else $error("enable read wrong");

  AST_RD_UNMAPPED: assert property (
    (s_rd_hit and reg_addr_i == 8'h47)
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  AST_SPEED_WR: assert property (
    clk_en_i && wr_speed && !bus_reset_i
    |=> speed_reg == $past(reg_wdata_i[NUM_PORTS-1:0]))
    else $error("speed write lost");

  AST_HIGH_EN: assert property (
    enable_w[7:4] == 4'h0)
    else $error("enable upper bits not zero");

  AST_SUSP_GATE: assert property (
    engine_suspend_i
    |-> dn_repeat_en_o == '0 && up_repeat_en_o == '0)
    else $error("suspended port repeats traffic");

  AST_FREEZE: assert property (
    !clk_en_i
    |=> $stable(attach_reg) && $stable(enable_reg) && $stable(speed_reg))
    else $error("state moved while clock enable low");

  AST_EOP_LOW: assert property (
    clk_en_i && !eof1_i
    |=> !eop_drive_o)
    else $error("end of packet without checkpoint");

  for (genvar q = 0; q < NUM_PORTS; q++) begin : g_chk
    AST_CON_SET: assert property (
      clk_en_i && g_port[q].set_w && !clr_w
      |=> attach_reg[q])
      else $error("qualified connect not recorded");

    AST_DIS_CLR: assert property (
      clk_en_i && g_port[q].clr_a_w && !clr_w
      |=> !attach_reg[q])
      else $error("qualified disconnect not recorded");

    AST_CNT_RESTART: assert property (
      clk_en_i && !g_port[q].same_w
      |=> g_port[q].cnt_reg == '0)
      else $error("qualifier did not restart");

    AST_DISABLED: assert property (
      !enable_reg[q]
      |-> !dn_repeat_en_o[q] && !up_repeat_en_o[q])
      else $error("disabled port repeats traffic");

    AST_OPEN: assert property (
      enable_reg[q] && !engine_suspend_i && !babble_i[q]
      |-> up_repeat_en_o[q])
      else $error("enabled port not opened upstream");

    AST_UP_BABBLE: assert property (
      babble_i[q]
      |-> !up_repeat_en_o[q])
      else $error("babbling port forwarded upstream");

    AST_EN_IDLE: assert property (
      clk_en_i && wr_enable && reg_wdata_i[q] && bus_idle_w && !clr_w && !babble_i[q]
      |=> enable_reg[q])
      else $error("enable not immediate on idle bus");

    AST_EN_OFF: assert property (
      clk_en_i && wr_enable && !reg_wdata_i[q]
      |=> !enable_reg[q])
      else $error("enable not cleared by write");

    AST_PEND_FIRE: assert property (
      clk_en_i && enable_pend_reg[q] && bus_idle_w && !clr_w && !wr_enable && !babble_i[q]
      |=> enable_reg[q])
      else $error("deferred enable not applied at packet end");

    AST_PEND_HOLD: assert property (
      clk_en_i && enable_pend_reg[q] && !bus_idle_w && !clr_w && !wr_enable && !babble_i[q]
      |=> enable_pend_reg[q])
      else $error("deferred enable lost mid packet");
  end

endmodule

// file: verification/usb_dev_model.sv
/*
  downstream device model: one attach and one speed level per port.
  assumes the bench sets the levels; pull-downs give SE0 when detached.
*/
`timescale 1ns/1ns
module usb_dev_model #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic [NUM_PORTS-1:0] attach_i,
  input  wire logic [NUM_PORTS-1:0] low_speed_i,
  output logic      [NUM_PORTS-1:0] dp_o,
  output logic      [NUM_PORTS-1:0] dm_o
);
  // full speed pulls D+ up, low speed pulls D- up, detached reads SE0
  assign dp_o = attach_i & ~low_speed_i;
  assign dm_o = attach_i & low_speed_i;
endmodule

// file: verification/hub_downstream_port_connect_enable_tb.sv
/*
  self-checking bench for the hub downstream port block.
  assumes the design package and the device model are compiled first.
*/
`timescale 1ns/1ns
module hub_downstream_port_connect_enable_tb;
  import hub_port_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic       clk = 1'b0, rst_n = 1'b0, bus_rst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       busy = 1'b0, eop = 1'b0, fs = 1'b0, eof1 = 1'b0, susp = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] attach = 4'h0, ls = 4'h0, babble = 4'h0, dp, dm, dn_en, up_en;
  logic       eop_drv, irq, en = 1'b1;
  logic [3:0] forced = 4'h0;
  int         n_errors = 0, total_checks = 0, cyc = 0, n;

  always #2 clk = ~clk;

  usb_dev_model #(.NUM_PORTS(4)) dev (.attach_i(attach), .low_speed_i(ls),
    .dp_o(dp), .dm_o(dm));

  hub_port_connect_enable #(.NUM_PORTS(4)) dut (
    .ref_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(en), .bus_reset_i(bus_rst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .dn_dp_i(dp), .dn_dm_i(dm), .port_forced_i(forced),
    .babble_i(babble), .up_busy_i(busy), .up_eop_i(eop), .up_full_speed_i(fs),
    .eof1_i(eof1), .engine_suspend_i(susp), .dn_repeat_en_o(dn_en),
    .up_repeat_en_o(up_en), .eop_drive_o(eop_drv), .hub_irq_o(irq));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // cycles from the current edge until the interrupt pulse shows
  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (irq !== 1'b1 && n < 2000);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(ATTACH_STATUS_OFS, 8'h00);
    rd_chk(PORT_ENABLE_OFS, 8'h00);
    rd_chk(SPEED_SELECT_OFS, 8'h00);
    rd_chk(8'h47, 8'h00);
  endtask

  task automatic t_attach_fs();
    @(posedge clk);
    attach[0] <= 1'b1;
    wait_irq();
    chk({7'h0, n > 625 && n <= 630}, 8'h01);
    rd_chk(ATTACH_STATUS_OFS, 8'h01);
  endtask

  task automatic t_attach_ls_glitch();
    @(posedge clk);
    ls[1] <= 1'b1; attach[1] <= 1'b1;
    repeat (400) @(posedge clk);
    attach[1] <= 1'b0;
    repeat (4) @(posedge clk);
    attach[1] <= 1'b1;
    wait_irq();
    chk({7'h0, n > 625 && n <= 630}, 8'h01);
    wr_reg(ATTACH_STATUS_OFS, 8'hF3);
    rd_chk(ATTACH_STATUS_OFS, 8'h03);
  endtask

  task automatic t_detach();
    @(posedge clk);
    attach[0] <= 1'b0;
    wait_irq();
    chk({7'h0, n >= 500 && n <= 626}, 8'h01);
    rd_chk(ATTACH_STATUS_OFS, 8'h02);
  endtask

  task automatic t_enable();
    wr_reg(SPEED_SELECT_OFS, 8'hF2);
    rd_chk(SPEED_SELECT_OFS, 8'h02);
    @(posedge clk);
    busy <= 1'b1;
    wr_reg(PORT_ENABLE_OFS, 8'h02);
    settle();
    chk({4'h0, dn_en}, 8'h00);
    @(posedge clk);
    eop <= 1'b1;
    @(posedge clk);
    eop <= 1'b0; busy <= 1'b0;
    settle();
    chk({4'h0, dn_en}, 8'h02);
    chk({4'h0, up_en}, 8'h02);
    @(posedge clk);
    fs <= 1'b1;
    settle();
    chk({4'h0, dn_en}, 8'h00);
    @(posedge clk);
    susp <= 1'b1;
    settle();
    chk({4'h0, up_en}, 8'h00);
    @(posedge clk);
    susp <= 1'b0; fs <= 1'b0; babble[1] <= 1'b1;
    @(posedge clk);
    babble[1] <= 1'b0;
    rd_chk(PORT_ENABLE_OFS, 8'h00);
  endtask

  task automatic t_eof();
    @(posedge clk);
    eof1 <= 1'b1;
    @(posedge clk);
    eof1 <= 1'b0;
    #1 chk({7'h0, eop_drv}, 8'h01);
  endtask

  task automatic t_suspend_irq();
    wr_reg(HUB_CTRL_OFS, 8'h03);
    @(posedge clk);
    attach[2] <= 1'b1; susp <= 1'b1;
    wait_irq();
    chk({7'h0, n < 2000}, 8'h01);
    rd_chk(ATTACH_STATUS_OFS, 8'h06);
    @(posedge clk);
    susp <= 1'b0;
    wr_reg(HUB_CTRL_OFS, 8'h00);
  endtask

  task automatic t_forced();
    @(posedge clk);
    forced <= 4'hF; attach[3] <= 1'b1;
    wait_irq();
    chk({7'h0, irq}, 8'h00);
    rd_chk(ATTACH_STATUS_OFS, 8'h0E);
    @(posedge clk);
    forced <= 4'h0;
  endtask

  task automatic t_freeze();
    @(posedge clk);
    en <= 1'b0;
    wr_reg(SPEED_SELECT_OFS, 8'h01);
    en <= 1'b1;
    rd_chk(SPEED_SELECT_OFS, 8'h00);
  endtask

  task automatic t_bus_reset();
    wr_reg(PORT_ENABLE_OFS, 8'h04);
    wr_reg(SPEED_SELECT_OFS, 8'h02);
    @(posedge clk);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    rd_chk(ATTACH_STATUS_OFS, 8'h00);
    rd_chk(PORT_ENABLE_OFS, 8'h00);
    rd_chk(SPEED_SELECT_OFS, 8'h00);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and timeout
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_attach_fs();
    t_attach_ls_glitch();
    t_detach();
    t_enable();
    t_eof();
    t_suspend_irq();
    t_forced();
    t_bus_reset();
    t_freeze();
    tally_and_finish();
  end
endmodule
